// [dv/hpma_props.sv]
// Checker of the host port pins and RAM request side
`timescale 1ns/100ps

module hpma_props (
   input wire logic ref_clk, // Block clock
   input wire logic sys_rst, // Sync reset
   input wire logic cpu_in_reset, // CPU held in reset
   input wire logic cpu_idle, // CPU idle
   input wire logic cpu_cpu_to_host_irq_bit_set, // CPU raises host interrupt
   input wire logic host_ready_q, // Host ready
   input wire logic host_int_n_q, // Host interrupt, low active
   input wire logic cpu_int_q, // Interrupt to CPU
   input wire logic external_memory_interface_enable_q, // Memory interface allowed
   input wire logic host_mux_mode_q, // Caught strap
   input wire logic [9:0] gpio_avail_q, // Spare pins
   input wire logic ram_req_q, // RAM request
   input wire logic ram_we_q, // RAM write
   input wire logic [15:0] ram_addr_q, // RAM word address
   input wire logic ram_ack // RAM done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   ////////////////////////////////////////////////////////////////////
   // Pin sharing follows the caught strap
   chk_plain_external_memory_interface_off: assert property (
      !host_mux_mode_q |-> !external_memory_interface_enable_q) else $error("external_memory_interface on in plain");
   chk_mux_external_memory_interface_on: assert property (
      host_mux_mode_q |-> external_memory_interface_enable_q) else $error("external_memory_interface off in mux");
   chk_spare_pins: assert property (
      $rose(host_ready_q) |-> gpio_avail_q ==
      (host_mux_mode_q ? 10'h0ff : 10'h300)) else $error("spare pin set");

   ////////////////////////////////////////////////////////////////////
   // RAM requests stay in the window and wait for the acknowledge
   chk_ram_window: assert property (
      ram_req_q |-> ram_addr_q >= 16'h0060) else $error("addr outside");
   chk_no_ram_rst: assert property (
      cpu_in_reset |=> !$rose(ram_req_q)) else $error("ram in cpu reset");
   chk_req_held: assert property (
      ram_req_q && !ram_ack |=> ram_req_q && $stable(ram_addr_q) &&
      $stable(ram_we_q) && !host_ready_q) else $error("req dropped");
   chk_ack_to_ready: assert property (
      ram_ack |-> ##[2:8] host_ready_q) else $error("ready late");

   ////////////////////////////////////////////////////////////////////
   // Interrupt bits in both directions
   chk_idle_no_wake: assert property (
      cpu_idle |=> !cpu_int_q) else $error("idle cpu woken");
   chk_cpu_to_host_irq_bit_raise: assert property (
      cpu_cpu_to_host_irq_bit_set |=> ##[0:2] !host_int_n_q) else $error("no host int");

   cov_ram_write: cover property (ram_ack && ram_we_q);
   cov_ram_read: cover property (ram_ack && !ram_we_q);
   cov_host_int: cover property ($fell(host_int_n_q));
endmodule

bind hpma_host_port hpma_props hpma_props_inst (.ref_clk, .sys_rst,
   .cpu_in_reset, .cpu_idle, .cpu_cpu_to_host_irq_bit_set, .host_ready_q, .host_int_n_q,
   .cpu_int_q, .external_memory_interface_enable_q, .host_mux_mode_q, .gpio_avail_q,
   .ram_req_q, .ram_we_q, .ram_addr_q, .ram_ack);

// [dv/hpma_ram_model.sv]
// Word RAM answering the executor with a settable delay
`timescale 1ns/100ps

module hpma_ram_model (
   input wire logic ref_clk, // Block clock
   input wire logic [2:0] lat, // Wait cycles before ack
   input wire logic req, // Request, held until ack
   input wire logic we, // Write
   input wire logic [15:0] addr, // Word address
   input wire logic [15:0] wdata, // Write word
   output logic [15:0] rdata, // Read word
   output logic ack // One cycle done
);
   logic [15:0] mem [0:65535];
   logic [2:0] cnt_q = 3'h0;

   // While no request is pending the read word toggles so nothing stale passes
   always @(posedge ref_clk) begin
      ack <= 1'b0;
      if (req && !ack) begin
         if (cnt_q == lat) begin
            ack <= 1'b1;
            cnt_q <= 3'h0;
            if (we) mem[addr] <= wdata;
            else rdata <= mem[addr];
         end else cnt_q <= cnt_q + 3'h1;
      end else if (!ack) rdata <= ~rdata;
   end

   initial begin
      ack = 1'b0;
      rdata = 16'h0000;
   end
endmodule

// [dv/tb_top.sv]
// Testbench of the host port in plain and multiplexed modes
`timescale 1ns/100ps

module tb_top;
   logic ref_clk = 0, sys_rst = 1, strap = 0, cs_n = 1, ds1_n = 1;
   logic ds2_n = 1, rw = 1, c0 = 1, c1 = 0, cres = 0, cidle = 0;
   logic hset = 0, iclr = 0, rdy, int_n, cint, external_memory_interface, muxm, req, we, ack;
   logic [1:0] cntl = 2'h0;
   logic [2:0] slow = 3'h0;
   logic [7:0] gdir = 8'h00;
   logic [9:0] avail, gin;
   logic [15:0] pa = 16'h0000, hd = 16'h0000, dout, oe_n, ra, wd, rd, q;
   wire logic [15:0] hdin = (oe_n & hd) | (~oe_n & dout);
   int fail_count = 0, n_checks = 0, i;

   hpma_host_port hpma_host_port_inst (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .host_mode_strap_pin(strap), .host_cs_n(cs_n),
      .host_ds1_n(ds1_n), .host_ds2_n(ds2_n), .host_rw(rw),
      .host_cntl(cntl), .host_ctrl_pin_zero(c0), .host_ctrl_pin_one(c1),
      .par_addr_pin(pa), .host_data_in(hdin), .host_data_out_q(dout),
      .host_data_oe_n_q(oe_n), .host_ready_q(rdy), .host_int_n_q(int_n),
      .cpu_in_reset(cres), .cpu_idle(cidle), .cpu_cpu_to_host_irq_bit_set(hset),
      .cpu_int_clr(iclr), .cpu_int_q(cint), .external_memory_interface_enable_q(external_memory_interface),
      .host_mux_mode_q(muxm), .gpio_out(8'h00), .gpio_dir(gdir),
      .gpio_in_q(gin), .gpio_avail_q(avail), .ram_req_q(req), .ram_we_q(we),
      .ram_addr_q(ra), .ram_wdata_q(wd), .ram_rdata(rd), .ram_ack(ack));

   hpma_ram_model hpma_ram_model_inst (.ref_clk(ref_clk), .lat(slow),
      .req(req), .we(we), .addr(ra), .wdata(wd), .rdata(rd), .ack(ack));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, exp, input string m);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Strap is only caught while reset is high
   task automatic rst(input logic s);
      strap = s;
      sys_rst = 1;
      repeat (5) @(posedge ref_clk);
      #1 sys_rst = 0;
   endtask

   // One host access; strobe held until ready, released only after it
   task automatic acc(input logic r, input logic [1:0] k,
      input logic [15:0] a, d, input logic s, two);
      @(posedge ref_clk) #1;
      rw = r;
      cntl = k;
      pa = a;
      c1 = s;
      c0 = 0;
      hd = r ? ~hd : d;
      @(posedge ref_clk) #1;
      cs_n = 0;
      if (two) ds2_n = 0;
      else ds1_n = 0;
      for (i = 0; i < 300 && rdy !== 1'b1; i++) @(posedge ref_clk);
      q = hdin;
      chk(i < 300, 1, "no ready");
      #1 cs_n = 1;
      ds1_n = 1;
      ds2_n = 1;
      c0 = 1;
      for (i = 0; i < 20 && rdy !== 1'b0; i++) @(posedge ref_clk);
      chk(rdy, 0, "ready stuck");
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      rst(0);
      chk(external_memory_interface, 0, "external_memory_interface plain");
      chk(muxm, 0, "mode plain");
      acc(0, 2'h3, 16'h0100, 16'ha5c3, 0, 0);
      acc(1, 2'h3, 16'h0100, 0, 0, 1);
      chk(q, 16'ha5c3, "word");
      chk(hpma_ram_model_inst.mem[256], 16'ha5c3, "word addr");
      // Autoincrement across three words
      acc(0, 2'h2, 0, 16'h0200, 0, 0);
      for (int j = 0; j < 3; j++) acc(0, 2'h1, 0, 16'h1000 + j, 0, 0);
      acc(0, 2'h2, 0, 16'h0200, 0, 0);
      for (int j = 0; j < 3; j++) begin
         acc(1, 2'h1, 0, 0, 0, 1);
         chk(q, 16'h1000 + j, "autoinc");
      end
      // Window edges, slow RAM on the lowest legal word
      slow = 3'h5;
      acc(0, 2'h3, 16'h0060, 16'h0bee, 0, 0);
      acc(0, 2'h3, 16'h005f, 16'hdead, 0, 0);
      acc(1, 2'h3, 16'h005f, 0, 0, 0);
      chk(q, 16'h0000, "below window");
      acc(1, 2'h3, 16'h0060, 0, 0, 0);
      chk(q, 16'h0bee, "window edge");
      slow = 3'h0;
      // Host to CPU interrupt while idle
      cidle = 1;
      acc(0, 2'h0, 0, 16'h0002, 0, 0);
      repeat (3) @(posedge ref_clk);
      chk(cint, 0, "idle woken");
      #1 cidle = 0;
      repeat (3) @(posedge ref_clk);
      chk(cint, 1, "cpu int");
      #1 iclr = 1;
      @(posedge ref_clk) #1 iclr = 0;
      // CPU to host interrupt
      hset = 1;
      @(posedge ref_clk) #1 hset = 0;
      repeat (2) @(posedge ref_clk);
      chk(int_n, 0, "host int");
      acc(1, 2'h0, 0, 0, 0, 0);
      chk(q & 16'h0006, 16'h0004, "ctrl read");
      acc(0, 2'h0, 0, 16'h0004, 0, 0);
      chk(int_n, 1, "int clear");
      // Access held off while the CPU is in reset
      cres = 1;
      fork
         acc(0, 2'h3, 16'h0400, 16'h7777, 0, 0);
         begin
            repeat (40) @(posedge ref_clk);
            chk(rdy, 0, "ready in reset");
            #1 cres = 0;
         end
      join
      chk(hpma_ram_model_inst.mem[1024], 16'h7777, "late write");
      // Multiplexed mode: bytes paired into words
      rst(1);
      chk(external_memory_interface, 1, "external_memory_interface mux");
      gdir = 8'h0f;
      hd = 16'hc000;
      repeat (5) @(posedge ref_clk);
      chk(avail, 16'h00ff, "spare mux");
      chk(oe_n[15:8], 16'h00f0, "spare dir");
      chk(gin, 16'h01c0, "spare in");
      acc(0, 2'h2, 0, 16'h0000, 0, 0);
      acc(0, 2'h2, 0, 16'h0003, 1, 0);
      acc(0, 2'h3, 0, 16'h0034, 0, 0);
      acc(0, 2'h3, 0, 16'h0012, 1, 0);
      chk(hpma_ram_model_inst.mem[768], 16'h1234, "byte pair");
      acc(1, 2'h3, 0, 0, 0, 0);
      chk(q[7:0], 16'h0034, "low byte");
      acc(1, 2'h3, 0, 0, 1, 0);
      chk(q[7:0], 16'h0012, "high byte");
      conclude();
   end

   // Cuts a hang well beyond the few hundred cycles the run needs
   initial begin
      repeat (30000) @(posedge ref_clk);
      fail_count++;
      conclude();
   end
endmodule

// [include/hpma_map.svh]
// Constants for the host port memory access block: codes, fields, resets
`ifndef HPMA_MAP_SVH
`define HPMA_MAP_SVH

// Host control code presented with each access
`define HPMA_CNTL_CTRL 2'h0
`define HPMA_CNTL_DATA_INC 2'h1
`define HPMA_CNTL_ADDR 2'h2
`define HPMA_CNTL_DATA 2'h3

// Control register field positions
`define HPMA_CTRL_TO_CPU_BIT 1
`define HPMA_CTRL_TO_HOST_BIT 2

// Word window of the dual access RAM that the host may reach
`define HPMA_RAM_LO 16'h0060
`define HPMA_RAM_HI 16'hffff

// Reset values
`define HPMA_ADDR_RST 16'h0000
`define HPMA_WORD_RST 16'h0000
`define HPMA_OE_N_RST 16'hffff

// Widths and depths
`define HPMA_PIN_SYNC_W 41
`define HPMA_CMD_W 33
`define HPMA_FIFO_DEPTH 8
`define HPMA_GPIO_W 8

`endif

// [include/hpma_pkg.sv]
// Types shared by the host port memory access block
package hpma_pkg;

   // Host side access sequencer
   typedef enum logic [3:0] {
      HPMA_IDLE = 4'h1,
      HPMA_ISSUE = 4'h2,
      HPMA_WAIT = 4'h4,
      HPMA_HOLD = 4'h8
   } hpma_host_st_t;

   // RAM side executor
   typedef enum logic [1:0] {
      HPMA_EX_IDLE = 2'h1,
      HPMA_EX_RAM = 2'h2
   } hpma_exec_st_t;

endpackage

// [verilog/hpma_fifo.sv]
// Command FIFO between the host sequencer and the RAM executor
`timescale 1ns/100ps

module hpma_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk, // Block clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic in_valid, // Source offers a word
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Word to store
   output logic out_valid, // A word is waiting
   input wire logic out_ready, // Sink takes the word
   output logic [WIDTH-1:0] out_data // Oldest word
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   // Full and empty come from the count, never from pointer compare
   assign in_ready = (count_q < (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Storage, written at the write index
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers wrap at the depth
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
      end
   end

   // Occupancy
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         count_q <= '0;
      end else if (push & ~pop) begin
         count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
         count_q <= count_q - 1'b1;
      end
   end

endmodule

// [verilog/hpma_host_port.sv]
// Host port giving an external host word access to the dual access RAM
//
// Contract
// - Strap at reset picks plain or multiplexed
// - Plain mode: address pins 17:2, data 15:0
// - Plain mode disables the external memory interface
// - Multiplexed: data 7:0, strobe, byte select
// - Multiplexed mode keeps external memory interface running
// - Only the RAM window past CPU registers
// - Host addresses are word addresses
// - Sixteen bit address register with autoincrement
// - Ready output paces every host access
// - No RAM access while the CPU is reset
// - Host interrupt write never wakes idle CPU
// - CPU to host interrupt lives in control register
// - Several strobe inputs for glueless hosts
// - Unused host pins serve as general purpose inputs; driven spare pins output low, gpio_out is not used
`timescale 1ns/100ps
`include "hpma_map.svh"

module hpma_host_port (
   input wire logic ref_clk, // 50 MHz block clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic host_mode_strap_pin, // Low plain, high multiplexed
   input wire logic host_cs_n, // Host chip select
   input wire logic host_ds1_n, // Host data strobe one
   input wire logic host_ds2_n, // Host data strobe two
   input wire logic host_rw, // High read, low write
   input wire logic [1:0] host_cntl, // Access kind
   input wire logic host_ctrl_pin_zero, // Address strobe, low active
   input wire logic host_ctrl_pin_one, // Byte select in multiplexed mode
   input wire logic [17:2] par_addr_pin, // Parallel port address pins
   input wire logic [15:0] host_data_in, // Data pins, level seen
   output logic [15:0] host_data_out_q, // Data pins, driven level
   output logic [15:0] host_data_oe_n_q, // Data pins, low drives
   output logic host_ready_q, // Access done when high
   output logic host_int_n_q, // Interrupt to host, low active
   input wire logic cpu_in_reset, // CPU core held in reset
   input wire logic cpu_idle, // CPU core in idle
   input wire logic cpu_cpu_to_host_irq_bit_set, // CPU raises host interrupt, pulse
   input wire logic cpu_int_clr, // CPU takes its interrupt, pulse
   output logic cpu_int_q, // Host interrupt to CPU, level
   output logic external_memory_interface_enable_q, // External memory interface allowed
   output logic host_mux_mode_q, // Caught strap
   input wire logic [7:0] gpio_out, // Spare data pin levels, not used; driven spare pins output low
   input wire logic [7:0] gpio_dir, // Spare data pin drive enables
   output logic [9:0] gpio_in_q, // Spare pins seen
   output logic [9:0] gpio_avail_q, // Spare pins free for general use
   output logic ram_req_q, // RAM request, held until ack
   output logic ram_we_q, // RAM write
   output logic [15:0] ram_addr_q, // RAM word address
   output logic [15:0] ram_wdata_q, // RAM write word
   input wire logic [15:0] ram_rdata, // RAM read word, valid with ack
   input wire logic ram_ack // RAM done, one cycle
);

   ////////////////////////////////////////////////////////////////////
   // Helpers

   // Pick the byte named by the byte select
   function automatic logic [7:0] byte_pick(logic [15:0] w, logic hi);
      byte_pick = hi ? w[15:8] : w[7:0];
   endfunction

   // Replace one byte of a word
   function automatic logic [15:0] byte_merge(logic [15:0] w,
                                              logic [7:0] b, logic hi);
      byte_merge = hi ? {b, w[7:0]} : {w[15:8], b};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [`HPMA_PIN_SYNC_W-1:0] sync1_q;
   logic [`HPMA_PIN_SYNC_W-1:0] sync2_q;
   logic strap_s;
   logic cs_n_s;
   logic ds1_n_s;
   logic ds2_n_s;
   logic rw_s;
   logic [1:0] cntl_s;
   logic c0_s;
   logic c1_s;
   logic [15:0] addr_s;
   logic [15:0] din_s;

   // Two stages before any logic looks at a pin
   always_ff @(posedge ref_clk) begin
      sync1_q <= {host_mode_strap_pin, host_cs_n, host_ds1_n, host_ds2_n,
                  host_rw, host_cntl, host_ctrl_pin_zero, host_ctrl_pin_one,
                  par_addr_pin, host_data_in};
      sync2_q <= sync1_q;
   end

   assign {strap_s, cs_n_s, ds1_n_s, ds2_n_s, rw_s, cntl_s, c0_s, c1_s,
           addr_s, din_s} = sync2_q;

   ////////////////////////////////////////////////////////////////////
   // Mode strap

   // Caught while reset is held, so it never changes in operation
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         host_mux_mode_q <= strap_s;
         external_memory_interface_enable_q <= strap_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Access decode

   hpma_pkg::hpma_host_st_t hst_q;
   logic strobe;
   logic as_seen_q;
   logic [1:0] as_cntl_q;
   logic as_bil_q;
   logic [1:0] acc_cntl;
   logic acc_hi;
   logic [7:0] acc_byte;

   // Any data strobe with chip select starts an access
   assign strobe = ~cs_n_s & ~(ds1_n_s & ds2_n_s);

   // Address strobe, when used, freezes kind and byte select early
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         as_seen_q <= 1'b0;
         as_cntl_q <= 2'h0;
         as_bil_q <= 1'b0;
      end else if (host_mux_mode_q & ~c0_s) begin
         as_seen_q <= 1'b1;
         as_cntl_q <= cntl_s;
         as_bil_q <= c1_s;
      end else if (hst_q == hpma_pkg::HPMA_HOLD & ~strobe) begin
         as_seen_q <= 1'b0;
      end
   end

   assign acc_cntl = as_seen_q ? as_cntl_q : cntl_s;
   assign acc_hi = as_seen_q ? as_bil_q : c1_s;
   assign acc_byte = din_s[7:0];

   ////////////////////////////////////////////////////////////////////
   // Host sequencer

   logic [15:0] addr_q;
   logic [15:0] wlatch_q;
   logic [15:0] rlatch_q;
   logic read_q;
   logic hi_q;
   logic inc_q;
   logic cmd_valid_q;
   logic [`HPMA_CMD_W-1:0] cmd_q;
   logic cmd_ready;
   logic done;
   logic [15:0] done_data;
   logic to_cpu_q;
   logic to_host_q;
   logic [15:0] ctrl_word;
   logic host_ctrl_wr;
   logic [15:0] ctrl_wdata;
   logic start;

   assign ctrl_word = {13'h0000, to_host_q, to_cpu_q, 1'b0};
   // The port waits out a CPU reset with ready low
   assign start = (hst_q == hpma_pkg::HPMA_IDLE) & strobe &
      ~cpu_in_reset;

   // One access at a time; ready rises only when the word is done
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hst_q <= hpma_pkg::HPMA_IDLE;
         host_ready_q <= 1'b0;
         read_q <= 1'b0;
         hi_q <= 1'b0;
         inc_q <= 1'b0;
         cmd_valid_q <= 1'b0;
         cmd_q <= '0;
         host_data_out_q <= `HPMA_WORD_RST;
      end else begin
         unique case (hst_q)
            hpma_pkg::HPMA_IDLE: begin
               host_ready_q <= 1'b0;
               read_q <= rw_s;
               hi_q <= acc_hi;
               inc_q <= 1'b0;
               if (start) begin
                  if (acc_cntl == `HPMA_CNTL_CTRL) begin
                     host_data_out_q <= host_mux_mode_q ?
                        {8'h00, byte_pick(ctrl_word, acc_hi)} : ctrl_word;
                     hst_q <= hpma_pkg::HPMA_HOLD;
                  end else if (acc_cntl == `HPMA_CNTL_ADDR) begin
                     host_data_out_q <= host_mux_mode_q ?
                        {8'h00, byte_pick(addr_q, acc_hi)} : addr_q;
                     hst_q <= hpma_pkg::HPMA_HOLD;
                  end else if (~host_mux_mode_q) begin
                     // Plain mode: full word, address from the pins
                     // unless the autoincrement kind is used
                     cmd_q <= {~rw_s,
                        (acc_cntl == `HPMA_CNTL_DATA) ? addr_s : addr_q,
                        din_s};
                     inc_q <= (acc_cntl == `HPMA_CNTL_DATA_INC);
                     cmd_valid_q <= 1'b1;
                     hst_q <= hpma_pkg::HPMA_ISSUE;
                  end else if (rw_s & ~acc_hi) begin
                     // First byte of a read fetches the whole word
                     cmd_q <= {1'b0, addr_q, `HPMA_WORD_RST};
                     cmd_valid_q <= 1'b1;
                     hst_q <= hpma_pkg::HPMA_ISSUE;
                  end else if (rw_s) begin
                     // Second byte of a read is served from the latch
                     host_data_out_q <= {8'h00, byte_pick(rlatch_q, 1'b1)};
                     inc_q <= (acc_cntl == `HPMA_CNTL_DATA_INC);
                     hst_q <= hpma_pkg::HPMA_HOLD;
                  end else if (acc_hi) begin
                     // Second byte of a write commits the word
                     cmd_q <= {1'b1, addr_q,
                        byte_merge(wlatch_q, acc_byte, 1'b1)};
                     inc_q <= (acc_cntl == `HPMA_CNTL_DATA_INC);
                     cmd_valid_q <= 1'b1;
                     hst_q <= hpma_pkg::HPMA_ISSUE;
                  end else begin
                     hst_q <= hpma_pkg::HPMA_HOLD;
                  end
               end
            end
            hpma_pkg::HPMA_ISSUE: begin
               // Held here while the FIFO is full
               if (cmd_ready) begin
                  cmd_valid_q <= 1'b0;
                  hst_q <= hpma_pkg::HPMA_WAIT;
               end
            end
            hpma_pkg::HPMA_WAIT: begin
               if (done) begin
                  host_data_out_q <= host_mux_mode_q ?
                     {8'h00, byte_pick(done_data, hi_q)} : done_data;
                  hst_q <= hpma_pkg::HPMA_HOLD;
               end
            end
            hpma_pkg::HPMA_HOLD: begin
               host_ready_q <= strobe;
               inc_q <= 1'b0;
               if (~strobe) begin
                  hst_q <= hpma_pkg::HPMA_IDLE;
               end
            end
         endcase
      end
   end

   // Address register: host loads it, data accesses may step it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         addr_q <= `HPMA_ADDR_RST;
      end else if (start & ~rw_s & acc_cntl == `HPMA_CNTL_ADDR) begin
         addr_q <= host_mux_mode_q ? byte_merge(addr_q, acc_byte, acc_hi)
            : din_s;
      end else if (hst_q == hpma_pkg::HPMA_HOLD & inc_q) begin
         addr_q <= addr_q + 16'h0001;
      end
   end

   // Byte latches for the multiplexed mode
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wlatch_q <= `HPMA_WORD_RST;
         rlatch_q <= `HPMA_WORD_RST;
      end else begin
         if (start & ~rw_s & acc_cntl[0] & host_mux_mode_q) begin
            wlatch_q <= byte_merge(wlatch_q, acc_byte, acc_hi);
         end
         if (done) begin
            rlatch_q <= done_data;
         end
      end
   end

   // Data pins drive during a read hold; spare pin drive enables follow gpio_dir
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         host_data_oe_n_q <= `HPMA_OE_N_RST;
      end else begin
         host_data_oe_n_q[7:0] <=
            {8{~(hst_q == hpma_pkg::HPMA_HOLD & read_q & strobe)}};
         host_data_oe_n_q[15:8] <= host_mux_mode_q ? ~gpio_dir
            : {8{~(hst_q == hpma_pkg::HPMA_HOLD & read_q & strobe)}};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Spare pins

   // Plain mode frees the strobe and byte select pins; the
   // multiplexed mode frees the upper data pins
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         gpio_in_q <= 10'h000;
         gpio_avail_q <= 10'h000;
      end else begin
         gpio_in_q <= {c1_s, c0_s, din_s[15:8]};
         gpio_avail_q <= host_mux_mode_q ? 10'h0ff : 10'h300;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control register interrupts

   assign host_ctrl_wr = start & ~rw_s & (acc_cntl == `HPMA_CNTL_CTRL);
   assign ctrl_wdata = host_mux_mode_q ?
      byte_merge(16'h0000, acc_byte, acc_hi) : din_s;

   // CPU to host flag: CPU sets, host clears by writing one; set wins
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         to_host_q <= 1'b0;
      end else if (cpu_cpu_to_host_irq_bit_set) begin
         to_host_q <= 1'b1;
      end else if (host_ctrl_wr & ctrl_wdata[`HPMA_CTRL_TO_HOST_BIT]) begin
         to_host_q <= 1'b0;
      end
   end

   // Host to CPU flag: host sets, CPU clears; set wins
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         to_cpu_q <= 1'b0;
      end else if (host_ctrl_wr & ctrl_wdata[`HPMA_CTRL_TO_CPU_BIT]) begin
         to_cpu_q <= 1'b1;
      end else if (cpu_int_clr) begin
         to_cpu_q <= 1'b0;
      end
   end

   // Idle CPU is never woken from here; the flag waits for it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cpu_int_q <= 1'b0;
         host_int_n_q <= 1'b1;
      end else begin
         cpu_int_q <= to_cpu_q & ~cpu_idle;
         host_int_n_q <= ~to_host_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command FIFO and RAM executor

   logic fifo_valid;
   logic [`HPMA_CMD_W-1:0] fifo_data;
   logic fifo_take;
   logic in_window;
   hpma_pkg::hpma_exec_st_t ex_q;
   logic done_q;
   logic [15:0] done_data_q;

   hpma_fifo #(
      .WIDTH(`HPMA_CMD_W),
      .DEPTH(`HPMA_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .in_valid(cmd_valid_q),
      .in_ready(cmd_ready),
      .in_data(cmd_q),
      .out_valid(fifo_valid),
      .out_ready(fifo_take),
      .out_data(fifo_data)
   );

   // Executor stalls the FIFO while busy or while the CPU is reset
   assign fifo_take = (ex_q == hpma_pkg::HPMA_EX_IDLE) & ~cpu_in_reset &
      ~done_q;
   assign in_window = (fifo_data[31:16] >= `HPMA_RAM_LO) &
      (fifo_data[31:16] <= `HPMA_RAM_HI);
   assign done = done_q;
   assign done_data = done_data_q;

   // Out of window words read as zero and writes are dropped
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ex_q <= hpma_pkg::HPMA_EX_IDLE;
         ram_req_q <= 1'b0;
         ram_we_q <= 1'b0;
         ram_addr_q <= `HPMA_ADDR_RST;
         ram_wdata_q <= `HPMA_WORD_RST;
         done_q <= 1'b0;
         done_data_q <= `HPMA_WORD_RST;
      end else begin
         done_q <= 1'b0;
         unique case (ex_q)
            hpma_pkg::HPMA_EX_IDLE: begin
               if (fifo_valid & fifo_take) begin
                  if (in_window) begin
                     ram_req_q <= 1'b1;
                     ram_we_q <= fifo_data[32];
                     ram_addr_q <= fifo_data[31:16];
                     ram_wdata_q <= fifo_data[15:0];
                     ex_q <= hpma_pkg::HPMA_EX_RAM;
                  end else begin
                     done_q <= 1'b1;
                     done_data_q <= `HPMA_WORD_RST;
                  end
               end
            end
            hpma_pkg::HPMA_EX_RAM: begin
               if (ram_ack) begin
                  ram_req_q <= 1'b0;
                  done_q <= 1'b1;
                  done_data_q <= ram_we_q ? ram_wdata_q : ram_rdata;
                  ex_q <= hpma_pkg::HPMA_EX_IDLE;
               end
            end
         endcase
      end
   end

endmodule
